// file: rtl/pplr_regs.sv
module pplr_regs
  import pplr_pkg::*;
#(
  parameter int          REFRESH_CYC   = PPLR_REFRESH_CYC,
  parameter int          TU_CYC        = PPLR_TU_CYC,
  parameter bit          HAS_SEC       = 1'b1,
  parameter bit          HAS_CORE_THR  = 1'b1,
  parameter bit          HAS_MEM       = 1'b1,
  parameter logic [14:0] MEM_SPEC_PWR  = 15'h0000,
  parameter logic [14:0] MEM_MIN_PWR   = 15'h0000,
  parameter logic [14:0] MEM_MAX_PWR   = 15'h0000,
  parameter logic [5:0]  MEM_MAX_WIN   = 6'h00
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire pplr_req_t   msr_req,
  output logic             msr_ack,
  output logic [63:0]      msr_rdata,
  input  wire logic [2:0]  energy_valid,
  input  wire logic [47:0] energy_amt,
  input  wire logic        core_throttled,
  input  wire logic        mem_throttled,
  output pplr_ctl_t        core_ctl,
  output pplr_ctl_t        sec_ctl,
  output pplr_ctl_t        mem_ctl,
  output logic [4:0]       core_prio,
  output logic [4:0]       sec_prio
);

  // ==========================================================
  // Stored settings
  pplr_cap_t   plane_cap_reg [2];
  logic [4:0]  plane_prio_reg [2];
  pplr_cap_t   mem_cap_reg;
  pplr_ctl_t   core_ctl_reg;
  pplr_ctl_t   sec_ctl_reg;
  pplr_ctl_t   mem_ctl_reg;
  logic [4:0]  core_prio_reg;
  logic [4:0]  sec_prio_reg;
  logic        msr_ack_reg;
  logic [63:0] msr_rdata_reg;
  logic [63:0] rdata_next;

  logic [31:0] refresh_cnt_reg;
  logic        refresh_tick;
  logic [31:0] thr_cnt_reg [2];
  logic [1:0]  thr_tick;
  logic [31:0] energy_count [3];
  logic [31:0] thr_count [2];
  logic [1:0]  throttled;

  function automatic pplr_cap_t cap_from_word(input logic [63:0] w, input logic has_clamp);
    pplr_cap_t c;
    c.limit    = w[PPLR_LIMIT_LSB +: PPLR_LIMIT_W];
    c.enable   = w[PPLR_EN_BIT];
    c.clamp    = has_clamp & w[PPLR_CLAMP_BIT];
    c.win_exp  = w[PPLR_WEXP_LSB +: PPLR_WEXP_W];
    c.win_frac = w[PPLR_WFRAC_LSB +: PPLR_WFRAC_W];
    c.lock     = w[PPLR_LOCK_BIT];
    return c;
  endfunction

  function automatic logic [63:0] word_from_cap(input pplr_cap_t c);
    logic [63:0] w;
    w = 64'h0;
    w[PPLR_LIMIT_LSB +: PPLR_LIMIT_W] = c.limit;
    w[PPLR_EN_BIT]                    = c.enable;
    w[PPLR_CLAMP_BIT]                 = c.clamp;
    w[PPLR_WEXP_LSB +: PPLR_WEXP_W]   = c.win_exp;
    w[PPLR_WFRAC_LSB +: PPLR_WFRAC_W] = c.win_frac;
    w[PPLR_LOCK_BIT]                  = c.lock;
    return w;
  endfunction

  // Window = 2^exp * (tenths / 10) time units
  function automatic pplr_ctl_t ctl_from_cap(input pplr_cap_t c);
    pplr_ctl_t k;
    k.enable     = c.enable;
    k.clamp      = c.clamp;
    k.limit      = c.limit;
    k.win_exp    = c.win_exp;
    k.win_tenths = PPLR_WIN_TENTHS + {2'b00, c.win_frac};
    return k;
  endfunction

  // ==========================================================
  // Write path
  logic wr_en;
  logic hit_core;
  logic hit_sec;
  logic hit_mem;
  logic hit_cap;
  logic hit_policy;
  logic core_wr_open;
  logic sec_wr_open;
  logic mem_wr_open;

  assign wr_en      = msr_req.req & msr_req.wr;
  assign hit_core   = (msr_req.dom == PPLR_DOM_CORE);
  assign hit_sec    = HAS_SEC && (msr_req.dom == PPLR_DOM_SEC);
  assign hit_mem    = HAS_MEM && (msr_req.dom == PPLR_DOM_MEM);
  assign hit_cap    = (msr_req.ofs == PPLR_OFS_CAP);
  assign hit_policy = (msr_req.ofs == PPLR_OFS_POLICY);

  // A set lock shuts the limit and the policy of its own plane only
  assign core_wr_open = wr_en && hit_core && !plane_cap_reg[0].lock;
  assign sec_wr_open  = wr_en && hit_sec && !plane_cap_reg[1].lock;
  assign mem_wr_open  = wr_en && hit_mem && !mem_cap_reg.lock;

  // Lock comes from the same word, so one write can set and lock
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      plane_cap_reg[0] <= '0;
      plane_cap_reg[1] <= '0;
    end else if (hit_cap) begin
      if (core_wr_open) begin
        plane_cap_reg[0] <= cap_from_word(msr_req.wdata, 1'b1);
      end
      if (sec_wr_open) begin
        plane_cap_reg[1] <= cap_from_word(msr_req.wdata, 1'b1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      plane_prio_reg[0] <= PPLR_CORE_PRIO_RST;
      plane_prio_reg[1] <= PPLR_SEC_PRIO_RST;
    end else if (hit_policy) begin
      if (core_wr_open) begin
        plane_prio_reg[0] <= msr_req.wdata[PPLR_PRIO_LSB +: PPLR_PRIO_W];
      end
      if (sec_wr_open) begin
        plane_prio_reg[1] <= msr_req.wdata[PPLR_PRIO_LSB +: PPLR_PRIO_W];
      end
    end
  end

  // Memory domain has no clamp bit
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mem_cap_reg <= '0;
    end else if (mem_wr_open && hit_cap) begin
      mem_cap_reg <= cap_from_word(msr_req.wdata, 1'b0);
    end
  end

  // ==========================================================
  // Settings handed to the budget controller
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      core_ctl_reg <= '0;
      sec_ctl_reg  <= '0;
      mem_ctl_reg  <= '0;
    end else begin
      core_ctl_reg <= ctl_from_cap(plane_cap_reg[0]);
      sec_ctl_reg  <= ctl_from_cap(plane_cap_reg[1]);
      mem_ctl_reg  <= ctl_from_cap(mem_cap_reg);
    end
  end

  // Priorities trail the policy registers by one cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      core_prio_reg <= PPLR_CORE_PRIO_RST;
      sec_prio_reg  <= PPLR_SEC_PRIO_RST;
    end else begin
      core_prio_reg <= plane_prio_reg[0];
      sec_prio_reg  <= plane_prio_reg[1];
    end
  end

  // ==========================================================
  // Refresh and time-unit timers
  assign refresh_tick = (refresh_cnt_reg == 32'(REFRESH_CYC - 1));

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      refresh_cnt_reg <= 32'h0;
    end else if (refresh_tick) begin
      refresh_cnt_reg <= 32'h0;
    end else begin
      refresh_cnt_reg <= refresh_cnt_reg + 32'h1;
    end
  end

  // Partial time units are kept while not throttled, so short bursts add up
  assign throttled = {mem_throttled & HAS_MEM, core_throttled & HAS_CORE_THR};

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      thr_cnt_reg[0] <= 32'h0;
      thr_cnt_reg[1] <= 32'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (thr_tick[i]) begin
          thr_cnt_reg[i] <= 32'h0;
        end else if (throttled[i]) begin
          thr_cnt_reg[i] <= thr_cnt_reg[i] + 32'h1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      thr_tick[i] = throttled[i] && (thr_cnt_reg[i] == 32'(TU_CYC - 1));
    end
  end

  // ==========================================================
  // Accumulators: core, secondary, memory energy; core, memory throttle
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_energy
      pplr_accum #(.AMT_W(16)) u_energy (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .add_valid (energy_valid[g]),
        .add_amt   (energy_amt[g*16 +: 16]),
        .publish   (refresh_tick),
        .count     (energy_count[g])
      );
    end
    for (g = 0; g < 2; g++) begin : g_throttle
      pplr_accum #(.AMT_W(1)) u_thr (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .add_valid (thr_tick[g]),
        .add_amt   (1'b1),
        .publish   (thr_tick[g]),
        .count     (thr_count[g])
      );
    end
  endgenerate

  // ==========================================================
  // Read path; absent or unmapped registers read as zero
  always_comb begin
    rdata_next = 64'h0;
    if (msr_req.dom == PPLR_DOM_CORE) begin
      if (msr_req.ofs == PPLR_OFS_CAP) begin
        rdata_next = word_from_cap(plane_cap_reg[0]);
      end else if (msr_req.ofs == PPLR_OFS_ENERGY) begin
        rdata_next = {32'h0, energy_count[0]};
      end else if (msr_req.ofs == PPLR_OFS_POLICY) begin
        rdata_next = {59'h0, plane_prio_reg[0]};
      end else if (msr_req.ofs == PPLR_OFS_THROTTLE && HAS_CORE_THR) begin
        rdata_next = {32'h0, thr_count[0]};
      end
    end else if (msr_req.dom == PPLR_DOM_SEC && HAS_SEC) begin
      if (msr_req.ofs == PPLR_OFS_CAP) begin
        rdata_next = word_from_cap(plane_cap_reg[1]);
      end else if (msr_req.ofs == PPLR_OFS_ENERGY) begin
        rdata_next = {32'h0, energy_count[1]};
      end else if (msr_req.ofs == PPLR_OFS_POLICY) begin
        rdata_next = {59'h0, plane_prio_reg[1]};
      end
    end else if (msr_req.dom == PPLR_DOM_MEM && HAS_MEM) begin
      if (msr_req.ofs == PPLR_OFS_CAP) begin
        rdata_next = word_from_cap(mem_cap_reg);
      end else if (msr_req.ofs == PPLR_OFS_ENERGY) begin
        rdata_next = {32'h0, energy_count[2]};
      end else if (msr_req.ofs == PPLR_OFS_THROTTLE) begin
        rdata_next = {32'h0, thr_count[1]};
      end else if (msr_req.ofs == PPLR_OFS_RANGE) begin
        rdata_next[PPLR_SPEC_LSB +: PPLR_LIMIT_W] = MEM_SPEC_PWR;
        rdata_next[PPLR_MINP_LSB +: PPLR_LIMIT_W] = MEM_MIN_PWR;
        rdata_next[PPLR_MAXP_LSB +: PPLR_LIMIT_W] = MEM_MAX_PWR;
        rdata_next[PPLR_MAXW_LSB +: PPLR_MAXW_W]  = MEM_MAX_WIN;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      msr_ack_reg <= 1'b0;
    end else begin
      msr_ack_reg <= msr_req.req;
    end
  end

  // Write acks return zero data
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      msr_rdata_reg <= 64'h0;
    end else begin
      msr_rdata_reg <= (msr_req.req && !msr_req.wr) ? rdata_next : 64'h0;
    end
  end

  // ==========================================================
  assign msr_ack   = msr_ack_reg;
  assign msr_rdata = msr_rdata_reg;
  assign core_ctl  = core_ctl_reg;
  assign sec_ctl   = sec_ctl_reg;
  assign mem_ctl   = mem_ctl_reg;
  assign core_prio = core_prio_reg;
  assign sec_prio  = sec_prio_reg;

endmodule

// file: rtl/pplr_pkg.sv
package pplr_pkg;

  // ==========================================================
  // Access port address: {domain, offset}
  localparam logic [1:0] PPLR_DOM_CORE = 2'h0;
  localparam logic [1:0] PPLR_DOM_SEC  = 2'h1;
  localparam logic [1:0] PPLR_DOM_MEM  = 2'h2;

  localparam logic [2:0] PPLR_OFS_CAP      = 3'h0;
  localparam logic [2:0] PPLR_OFS_ENERGY   = 3'h1;
  localparam logic [2:0] PPLR_OFS_POLICY   = 3'h2;
  localparam logic [2:0] PPLR_OFS_THROTTLE = 3'h3;
  localparam logic [2:0] PPLR_OFS_RANGE    = 3'h4;

  // ==========================================================
  // Limit and policy register field positions
  localparam int PPLR_LIMIT_LSB  = 0;
  localparam int PPLR_LIMIT_W    = 15;
  localparam int PPLR_EN_BIT     = 15;
  localparam int PPLR_CLAMP_BIT  = 16;
  localparam int PPLR_WEXP_LSB   = 17;
  localparam int PPLR_WEXP_W     = 5;
  localparam int PPLR_WFRAC_LSB  = 22;
  localparam int PPLR_WFRAC_W    = 2;
  localparam int PPLR_LOCK_BIT   = 31;
  localparam int PPLR_PRIO_LSB   = 0;
  localparam int PPLR_PRIO_W     = 5;

  // Range register field positions
  localparam int PPLR_SPEC_LSB   = 0;
  localparam int PPLR_MINP_LSB   = 16;
  localparam int PPLR_MAXP_LSB   = 32;
  localparam int PPLR_MAXW_LSB   = 48;
  localparam int PPLR_MAXW_W     = 6;

  // ==========================================================
  // Reset values
  localparam logic [4:0]  PPLR_CORE_PRIO_RST = 5'h00;
  localparam logic [4:0]  PPLR_SEC_PRIO_RST  = 5'h10;
  localparam logic [3:0]  PPLR_TU_RST        = 4'hA;
  localparam logic [3:0]  PPLR_WIN_TENTHS    = 4'hA;

  // ==========================================================
  // Timing
  localparam int PPLR_CLK_HZ        = 50_000_000;
  localparam int PPLR_REFRESH_US    = 1000;
  localparam int PPLR_REFRESH_CYC   = PPLR_CLK_HZ / 1_000_000 * PPLR_REFRESH_US;
  localparam int PPLR_TU_CYC        = PPLR_CLK_HZ >> PPLR_TU_RST;

  // ==========================================================
  typedef struct packed {
    logic        lock;
    logic [1:0]  win_frac;
    logic [4:0]  win_exp;
    logic        clamp;
    logic        enable;
    logic [14:0] limit;
  } pplr_cap_t;

  // Decoded limit handed to the budget controller
  typedef struct packed {
    logic        enable;
    logic        clamp;
    logic [14:0] limit;
    logic [4:0]  win_exp;
    logic [3:0]  win_tenths;
  } pplr_ctl_t;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [1:0]  dom;
    logic [2:0]  ofs;
    logic [63:0] wdata;
  } pplr_req_t;

endpackage

// file: rtl/pplr_accum.sv
module pplr_accum
  import pplr_pkg::*;
#(
  parameter int AMT_W = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             add_valid,
  input  wire logic [AMT_W-1:0] add_amt,
  input  wire logic             publish,
  output logic      [31:0]      count
);

  logic [31:0] pending_reg;
  logic [31:0] pending_next;
  logic [31:0] count_reg;

  always_comb begin
    pending_next = pending_reg;
    if (add_valid) begin
      pending_next = pending_reg + 32'(add_amt);
    end
  end

  // Visible value only moves on publish; both wrap silently
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pending_reg <= 32'h0;
      count_reg   <= 32'h0;
    end else if (publish) begin
      pending_reg <= 32'h0;
      count_reg   <= count_reg + pending_next;
    end else begin
      pending_reg <= pending_next;
    end
  end

  assign count = count_reg;

endmodule

// file: sim/pplr_regs_monitor.sv
module pplr_regs_monitor
  import pplr_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire pplr_req_t   msr_req,
  input wire logic        msr_ack,
  input wire logic [63:0] msr_rdata,
  input wire pplr_ctl_t   core_ctl,
  input wire pplr_ctl_t   mem_ctl,
  input wire logic [4:0]  core_prio,
  input wire logic [4:0]  sec_prio
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] lk_reg;

  // ==========================================================
  // Lock shadow, so lock checks need no look inside the design
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lk_reg <= 3'h0;
    end else if (msr_req.req && msr_req.wr && msr_req.ofs == PPLR_OFS_CAP &&
                 msr_req.wdata[31] && msr_req.dom != 2'h3) begin
      lk_reg[msr_req.dom] <= 1'b1;
    end
  end

  // ==========================================================
  // Properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_cap_wr(logic [1:0] d);
    msr_req.req && msr_req.wr && msr_req.dom == d && msr_req.ofs == PPLR_OFS_CAP;
  endsequence
  sequence s_pol_wr(logic [1:0] d);
    msr_req.req && msr_req.wr && msr_req.dom == d && msr_req.ofs == PPLR_OFS_POLICY;
  endsequence

  property p_ack; msr_req.req |=> msr_ack; endproperty
  property p_wr_zero; msr_req.req && msr_req.wr |=> msr_rdata == 64'h0; endproperty
  property p_idle_zero; !msr_ack |-> msr_rdata == 64'h0; endproperty
  property p_core_set;
    s_cap_wr(PPLR_DOM_CORE) ##0 !lk_reg[0] |-> ##2
      core_ctl.limit == $past(msr_req.wdata[14:0], 2) &&
      core_ctl.enable == $past(msr_req.wdata[15], 2) &&
      core_ctl.clamp == $past(msr_req.wdata[16], 2);
  endproperty
  property p_core_lock;
    s_cap_wr(PPLR_DOM_CORE) ##0 lk_reg[0] |-> ##2 $stable(core_ctl);
  endproperty
  property p_pol_lock;
    s_pol_wr(PPLR_DOM_CORE) ##0 lk_reg[0] |-> ##2 $stable(core_prio);
  endproperty
  property p_sec_pol;
    s_pol_wr(PPLR_DOM_SEC) ##0 !lk_reg[1] |-> ##2 sec_prio == $past(msr_req.wdata[4:0], 2);
  endproperty
  property p_mem_set;
    s_cap_wr(PPLR_DOM_MEM) ##0 !lk_reg[2] |-> ##2
      mem_ctl.limit == $past(msr_req.wdata[14:0], 2) && !mem_ctl.clamp;
  endproperty
  property p_mem_lock;
    s_cap_wr(PPLR_DOM_MEM) ##0 lk_reg[2] |-> ##2 $stable(mem_ctl);
  endproperty
  property p_sec_rst; $rose(resetn) |-> sec_prio == PPLR_SEC_PRIO_RST; endproperty

  a_ack: assert property (p_ack) else $error("no ack after request");
  a_wr_zero: assert property (p_wr_zero) else $error("write ack carries data");
  a_idle_zero: assert property (p_idle_zero) else $error("read data while idle");
  a_core_set: assert property (p_core_set) else $error("core limit not applied");
  a_core_lock: assert property (p_core_lock) else $error("locked core limit moved");
  a_pol_lock: assert property (p_pol_lock) else $error("locked policy moved");
  a_sec_pol: assert property (p_sec_pol) else $error("priority not applied");
  a_mem_set: assert property (p_mem_set) else $error("memory limit wrong");
  a_mem_lock: assert property (p_mem_lock) else $error("locked memory limit moved");
  a_sec_rst: assert property (p_sec_rst) else $error("priority reset wrong");
endmodule

bind pplr_regs pplr_regs_monitor u_mon (
  .clk_sys   (clk_sys),
  .resetn    (resetn),
  .msr_req   (msr_req),
  .msr_ack   (msr_ack),
  .msr_rdata (msr_rdata),
  .core_ctl  (core_ctl),
  .mem_ctl   (mem_ctl),
  .core_prio (core_prio),
  .sec_prio  (sec_prio)
);

// file: sim/pplr_regs_tb_top.sv
module pplr_regs_tb_top
  import pplr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys;
  logic        resetn;
  pplr_req_t   msr_req;
  logic        msr_ack;
  logic [63:0] msr_rdata;
  logic [2:0]  energy_valid;
  logic [47:0] energy_amt;
  logic        core_throttled;
  logic        mem_throttled;
  pplr_ctl_t   core_ctl;
  pplr_ctl_t   sec_ctl;
  pplr_ctl_t   mem_ctl;
  logic [4:0]  core_prio;
  logic [4:0]  sec_prio;
  int          bad_count;
  int          checks_done;

  pplr_regs #(
    .REFRESH_CYC  (20),
    .TU_CYC       (8),
    .MEM_MIN_PWR  (15'h0456),
    .MEM_MAX_PWR  (15'h7ABC),
    .MEM_MAX_WIN  (6'h2A)
  ) DUT (
    .clk_sys        (clk_sys),
    .resetn         (resetn),
    .msr_req        (msr_req),
    .msr_ack        (msr_ack),
    .msr_rdata      (msr_rdata),
    .energy_valid   (energy_valid),
    .energy_amt     (energy_amt),
    .core_throttled (core_throttled),
    .mem_throttled  (mem_throttled),
    .core_ctl       (core_ctl),
    .sec_ctl        (sec_ctl),
    .mem_ctl        (mem_ctl),
    .core_prio      (core_prio),
    .sec_prio       (sec_prio)
  );

  // ==========================================================
  // Tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Entered just after an edge; returns one edge after the ack cycle
  task automatic acc(input logic wr, input logic [1:0] d, input logic [2:0] o,
                     input logic [63:0] wd, output logic [63:0] rd);
    msr_req <= '{req: 1'b1, wr: wr, dom: d, ofs: o, wdata: wd};
    @(posedge clk_sys);
    msr_req.req <= 1'b0;
    #1;
    chk(64'(msr_ack), 64'h1);
    rd = msr_rdata;
    @(posedge clk_sys);
  endtask

  task automatic wrr(input logic [1:0] d, input logic [2:0] o, input logic [63:0] wd);
    logic [63:0] rd;
    acc(1'b1, d, o, wd, rd);
    chk(rd, 64'h0);
  endtask

  task automatic rdc(input logic [1:0] d, input logic [2:0] o, input logic [63:0] exp);
    logic [63:0] rd;
    acc(1'b0, d, o, 64'h0, rd);
    chk(rd, exp);
  endtask

  task automatic stop_test();
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Clock, watchdog
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (3000) @(posedge clk_sys);
    bad_count++;
    stop_test();
  end

  // ==========================================================
  // Tests
  initial begin
    resetn = 1'b0;
    msr_req = '0;
    energy_valid = 3'h0;
    energy_amt = 48'h0;
    core_throttled = 1'b0;
    mem_throttled = 1'b0;
    bad_count = 0;
    checks_done = 0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rdc(PPLR_DOM_CORE, PPLR_OFS_POLICY, 64'h0);
    rdc(PPLR_DOM_SEC, PPLR_OFS_POLICY, 64'h10);
    chk(64'(sec_prio), 64'h10);
    wrr(PPLR_DOM_CORE, PPLR_OFS_CAP, 64'hFFFF_FFFF_7FFF_FFFF);
    rdc(PPLR_DOM_CORE, PPLR_OFS_CAP, 64'h00FF_FFFF);
    chk(64'(core_ctl), 64'(pplr_ctl_t'{1'b1, 1'b1, 15'h7FFF, 5'h1F, 4'hD}));
    for (int z = 0; z < 4; z++) begin
      wrr(PPLR_DOM_CORE, PPLR_OFS_CAP, {40'h0, 2'(z), 5'h03, 2'b01, 15'h0100});
      @(posedge clk_sys);
      chk(64'(core_ctl.win_tenths), 64'(10 + z));
      chk(64'(core_ctl.win_exp), 64'h3);
    end
    wrr(PPLR_DOM_CORE, PPLR_OFS_POLICY, 64'hFFFF);
    rdc(PPLR_DOM_CORE, PPLR_OFS_POLICY, 64'h1F);
    chk(64'(core_prio), 64'h1F);
    wrr(PPLR_DOM_CORE, PPLR_OFS_CAP, 64'h8000_1234);
    wrr(PPLR_DOM_CORE, PPLR_OFS_CAP, 64'h5555);
    rdc(PPLR_DOM_CORE, PPLR_OFS_CAP, 64'h8000_1234);
    wrr(PPLR_DOM_CORE, PPLR_OFS_POLICY, 64'h3);
    rdc(PPLR_DOM_CORE, PPLR_OFS_POLICY, 64'h1F);
    wrr(PPLR_DOM_SEC, PPLR_OFS_CAP, 64'h8055);
    rdc(PPLR_DOM_SEC, PPLR_OFS_CAP, 64'h8055);
    chk(64'(sec_ctl.limit), 64'h55);
    wrr(PPLR_DOM_SEC, PPLR_OFS_POLICY, 64'h5);
    rdc(PPLR_DOM_SEC, PPLR_OFS_POLICY, 64'h5);
    wrr(PPLR_DOM_MEM, PPLR_OFS_CAP, 64'h8001_8077);
    rdc(PPLR_DOM_MEM, PPLR_OFS_CAP, 64'h8000_8077);
    chk(64'(mem_ctl), 64'(pplr_ctl_t'{1'b1, 1'b0, 15'h77, 5'h0, 4'hA}));
    wrr(PPLR_DOM_MEM, PPLR_OFS_CAP, 64'h0);
    rdc(PPLR_DOM_MEM, PPLR_OFS_CAP, 64'h8000_8077);
    wrr(PPLR_DOM_MEM, PPLR_OFS_RANGE, '1);
    rdc(PPLR_DOM_MEM, PPLR_OFS_RANGE, 64'h002A_7ABC_0456_0000);
    rdc(2'h3, PPLR_OFS_CAP, 64'h0);
    rdc(PPLR_DOM_SEC, PPLR_OFS_THROTTLE, 64'h0);
    wrr(PPLR_DOM_CORE, PPLR_OFS_ENERGY, '1);
    energy_valid <= 3'b101;
    energy_amt <= {16'h0300, 16'h0, 16'h0021};
    repeat (4) @(posedge clk_sys);
    energy_valid <= 3'h0;
    repeat (60) @(posedge clk_sys);
    rdc(PPLR_DOM_CORE, PPLR_OFS_ENERGY, 64'h84);
    rdc(PPLR_DOM_SEC, PPLR_OFS_ENERGY, 64'h0);
    rdc(PPLR_DOM_MEM, PPLR_OFS_ENERGY, 64'hC00);
    core_throttled <= 1'b1;
    mem_throttled <= 1'b1;
    repeat (16) @(posedge clk_sys);
    mem_throttled <= 1'b0;
    repeat (8) @(posedge clk_sys);
    core_throttled <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rdc(PPLR_DOM_CORE, PPLR_OFS_THROTTLE, 64'h3);
    rdc(PPLR_DOM_MEM, PPLR_OFS_THROTTLE, 64'h2);
    stop_test();
  end
endmodule
